// ---- rtl/mifd_decoder.sv ----
/*
  mifd_decoder: instruction field decoder of an 8-bit core.
  assumes: program memory presents a word with instr_valid after
  fetch_req; the register port master follows the plain strobe protocol.
*/
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module mifd_decoder #(
  parameter int ADDR_W = 8,
  parameter int PERIODS = mifd_pkg::CYCLE_PERIODS
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // program memory
  output logic fetch_req,
  input wire logic [15:0] instr_word,
  input wire logic instr_valid,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // decode results
  output logic dec_valid,
  output mifd_pkg::mifd_op_t dec_op,
  output mifd_pkg::mifd_fields_t dec_fields,
  output logic [11:0] dec_file_addr,
  output logic [11:0] dec_src_addr,
  output logic [11:0] dec_dst_addr,
  output logic [19:0] dec_target,
  output logic dec_result_to_file,
  output logic [4:0] dec_flag_mask,
  output logic dec_skip_cond,
  output logic [1:0] dec_cycles,
  // shadow register control
  output logic shadow_save,
  output logic shadow_restore,
  // table access
  output logic [mifd_pkg::TABLE_PTR_W-1:0] table_pointer
);

  // refuse an address port too narrow for the map
  if (ADDR_W < 5) begin : g_chk
    $error("ADDR_W must be at least 5");
  end

  // ------------------------------------------------------------------
  // opcode classifier
  // ------------------------------------------------------------------
  function automatic mifd_pkg::mifd_op_t classify(input logic [15:0] w);
    mifd_pkg::mifd_op_t op;
    op = mifd_pkg::OP_OTHER;
    casez (w)
      mifd_pkg::PAT_ADD: op = mifd_pkg::OP_ADD;
      mifd_pkg::PAT_ADDC: op = mifd_pkg::OP_ADDC;
      mifd_pkg::PAT_DECSZ: op = mifd_pkg::OP_DECSZ;
      mifd_pkg::PAT_DECSNZ: op = mifd_pkg::OP_DECSNZ;
      mifd_pkg::PAT_AND: op = mifd_pkg::OP_AND;
      mifd_pkg::PAT_COMP: op = mifd_pkg::OP_COMP;
      mifd_pkg::PAT_CLR: op = mifd_pkg::OP_CLR;
      mifd_pkg::PAT_CPEQ: op = mifd_pkg::OP_CPEQ;
      mifd_pkg::PAT_CPGT: op = mifd_pkg::OP_CPGT;
      mifd_pkg::PAT_CPLT: op = mifd_pkg::OP_CPLT;
      mifd_pkg::PAT_FILE_MOVE: op = mifd_pkg::OP_FILE_MOVE;
      mifd_pkg::PAT_GOTO: op = mifd_pkg::OP_GOTO;
      mifd_pkg::PAT_CALL: op = mifd_pkg::OP_CALL;
      mifd_pkg::PAT_RET: op = mifd_pkg::OP_RET;
      mifd_pkg::PAT_REL_BRANCH: op = mifd_pkg::OP_REL_BRANCH;
      mifd_pkg::PAT_LIT: op = mifd_pkg::OP_OTHER;
      mifd_pkg::PAT_SECOND: op = mifd_pkg::OP_NOP;
      default: op = mifd_pkg::OP_OTHER;
    endcase
    return op;
  endfunction

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  logic cyc_first; // first period of a cycle
  logic cyc_last; // last period of a cycle
  logic [15:0] pend_word_ff; // word waiting for the cycle end
  logic pend_ff; // pend_word_ff holds a word
  logic [15:0] first_word_ff; // opening word of a pair
  mifd_pkg::mifd_seq_t seq_ff; // two-word sequence state
  mifd_pkg::mifd_seq_t nxt_seq;
  logic ctrl_en_ff; // decode enable
  logic [mifd_pkg::BANK_W-1:0] bank_select_reg_ff;
  logic [mifd_pkg::TABLE_PTR_W-1:0] table_pointer_ff;
  logic err_ff; // sticky: pair broken by a bad word
  logic [15:0] last_word_ff; // word behind the last result

  // combinational decode
  logic decode_now; // cycle end with a word in hand
  logic open_pair; // word opens a two-word pair
  logic close_pair; // word completes a pair
  logic break_pair; // second word missing its 1111 nibble
  logic emit; // a result goes out this cycle
  logic [15:0] emit_word; // word whose fields are reported
  mifd_pkg::mifd_op_t word_op; // class of the pending word
  mifd_pkg::mifd_op_t emit_op; // class reported
  mifd_pkg::mifd_fields_t emit_fields;

  // ------------------------------------------------------------------
  // submodules
  // ------------------------------------------------------------------
  mifd_phase_gen #(
    .PERIODS(PERIODS)
  ) u_phase (
    .clk(clk),
    .sys_rst(sys_rst),
    .cyc_first(cyc_first),
    .cyc_last(cyc_last)
  );

  mifd_field_split u_split (
    .word(emit_word),
    .fields(emit_fields)
  );

  // ------------------------------------------------------------------
  // pair handling
  // ------------------------------------------------------------------
  always_comb begin
    decode_now = cyc_last && pend_ff && ctrl_en_ff;
    word_op = classify(pend_word_ff);
    open_pair = 1'b0;
    close_pair = 1'b0;
    break_pair = 1'b0;
    nxt_seq = seq_ff;
    case (seq_ff)
      mifd_pkg::SEQ_FIRST: begin
        // file moves, jumps and calls wait for their second word
        if (decode_now && (word_op == mifd_pkg::OP_FILE_MOVE ||
            word_op == mifd_pkg::OP_GOTO || word_op == mifd_pkg::OP_CALL)) begin
          open_pair = 1'b1;
          nxt_seq = mifd_pkg::SEQ_SECOND;
        end
      end
      mifd_pkg::SEQ_SECOND: begin
        if (decode_now) begin
          close_pair = (pend_word_ff[15:12] == mifd_pkg::NIB_SECOND);
          break_pair = !close_pair;
          nxt_seq = mifd_pkg::SEQ_FIRST;
        end
      end
      default: nxt_seq = mifd_pkg::SEQ_FIRST;
    endcase
    emit = decode_now && !open_pair;
    // a completed pair reports the opening word's operands
    emit_word = close_pair ? first_word_ff : pend_word_ff;
    if (close_pair) begin
      emit_op = classify(first_word_ff);
    end else if (break_pair) begin
      emit_op = mifd_pkg::OP_NOP; // broken pair is dropped
    end else begin
      emit_op = word_op;
    end
  end

  // ------------------------------------------------------------------
  // fetch request, once per instruction cycle
  // ------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fetch_req <= 1'b0;
    end else begin
      fetch_req <= cyc_first && ctrl_en_ff;
    end
  end

  // ------------------------------------------------------------------
  // incoming word holding register
  // ------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pend_word_ff <= 16'h0000;
      pend_ff <= 1'b0;
    end else if (instr_valid) begin
      // a new word wins over the consume
      pend_word_ff <= instr_word;
      pend_ff <= 1'b1;
    end else if (decode_now) begin
      pend_ff <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // two-word sequence
  // ------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      seq_ff <= mifd_pkg::SEQ_FIRST;
      first_word_ff <= 16'h0000;
    end else begin
      seq_ff <= nxt_seq;
      if (open_pair) begin
        first_word_ff <= pend_word_ff;
      end
    end
  end

  // ------------------------------------------------------------------
  // decoded outputs, loaded at the end of the cycle
  // ------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dec_valid <= 1'b0;
      dec_op <= mifd_pkg::OP_NOP;
      dec_fields <= '0;
      dec_file_addr <= 12'h000;
      dec_src_addr <= 12'h000;
      dec_dst_addr <= 12'h000;
      dec_target <= 20'h00000;
      dec_result_to_file <= 1'b0;
      dec_flag_mask <= mifd_pkg::FLG_NONE;
      dec_skip_cond <= 1'b0;
      dec_cycles <= mifd_pkg::CYC_ONE;
      last_word_ff <= 16'h0000;
    end else begin
      dec_valid <= emit;
      if (emit) begin
        dec_op <= emit_op;
        dec_fields <= emit_fields;
        last_word_ff <= emit_word;
        // bank choice for the 8-bit address
        if (emit_fields.bank_sel) begin
          dec_file_addr <= {bank_select_reg_ff, emit_fields.file_addr};
        end else if (emit_fields.file_addr[7]) begin
          dec_file_addr <= {mifd_pkg::ACCESS_HI_BANK, emit_fields.file_addr};
        end else begin
          dec_file_addr <= {mifd_pkg::ACCESS_LO_BANK, emit_fields.file_addr};
        end
        // operands carried across both words
        dec_src_addr <= first_word_ff[11:0];
        dec_dst_addr <= pend_word_ff[11:0];
        dec_target <= {pend_word_ff[11:0], first_word_ff[7:0]};
        // destination select only for ops that have a d bit
        case (emit_op)
          mifd_pkg::OP_ADD, mifd_pkg::OP_ADDC, mifd_pkg::OP_AND,
          mifd_pkg::OP_COMP, mifd_pkg::OP_DECSZ, mifd_pkg::OP_DECSNZ: begin
            dec_result_to_file <= emit_fields.dest_file;
          end
          mifd_pkg::OP_CLR: begin
            dec_result_to_file <= 1'b1;
          end
          default: begin
            dec_result_to_file <= 1'b0;
          end
        endcase
        // status flags each op may change
        case (emit_op)
          mifd_pkg::OP_ADD, mifd_pkg::OP_ADDC: begin
            dec_flag_mask <= mifd_pkg::FLG_ARITH;
          end
          mifd_pkg::OP_AND, mifd_pkg::OP_COMP: begin
            dec_flag_mask <= mifd_pkg::FLG_ZN;
          end
          mifd_pkg::OP_CLR: begin
            dec_flag_mask <= mifd_pkg::FLG_Z;
          end
          default: begin
            dec_flag_mask <= mifd_pkg::FLG_NONE;
          end
        endcase
        // skip candidates; the ALU decides the outcome
        case (emit_op)
          mifd_pkg::OP_CPEQ, mifd_pkg::OP_CPGT, mifd_pkg::OP_CPLT: begin
            dec_skip_cond <= 1'b1;
          end
          mifd_pkg::OP_DECSZ, mifd_pkg::OP_DECSNZ: begin
            dec_skip_cond <= 1'b1;
          end
          default: begin
            dec_skip_cond <= 1'b0;
          end
        endcase
        // base cycle count, before any skip is taken
        case (emit_op)
          mifd_pkg::OP_FILE_MOVE, mifd_pkg::OP_GOTO, mifd_pkg::OP_CALL,
          mifd_pkg::OP_RET, mifd_pkg::OP_REL_BRANCH: begin
            dec_cycles <= mifd_pkg::CYC_TWO;
          end
          default: begin
            dec_cycles <= mifd_pkg::CYC_ONE;
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // shadow register strobes, one cycle each
  // ------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      shadow_save <= 1'b0;
      shadow_restore <= 1'b0;
    end else begin
      // s=0 keeps both low; s=1 fires the matching strobe
      shadow_save <= emit && emit_op == mifd_pkg::OP_CALL &&
                     emit_fields.fast;
      shadow_restore <= emit && emit_op == mifd_pkg::OP_RET &&
                        emit_fields.fast;
    end
  end

  // ------------------------------------------------------------------
  // sticky broken-pair flag; a set beats a clear
  // ------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      err_ff <= 1'b0;
    end else if (break_pair) begin
      err_ff <= 1'b1;
    end else if (reg_wr && reg_addr == ADDR_W'(mifd_pkg::REG_STATUS) &&
                 reg_wdata[mifd_pkg::STAT_ERR_BIT]) begin
      err_ff <= 1'b0; // write one to clear
    end
  end

  // ------------------------------------------------------------------
  // software-written registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_en_ff <= mifd_pkg::CTRL_EN_RST;
      bank_select_reg_ff <= '0;
      table_pointer_ff <= '0;
    end else if (reg_wr) begin
      case (reg_addr)
        ADDR_W'(mifd_pkg::REG_CTRL): begin
          ctrl_en_ff <= reg_wdata[mifd_pkg::CTRL_EN_BIT];
        end
        ADDR_W'(mifd_pkg::REG_BANK): begin
          bank_select_reg_ff <= reg_wdata[mifd_pkg::BANK_W-1:0];
        end
        ADDR_W'(mifd_pkg::REG_TABLE_PTR): begin
          table_pointer_ff <= reg_wdata[mifd_pkg::TABLE_PTR_W-1:0];
        end
        default: begin
          // unmapped or read-only: ignored
        end
      endcase
    end
  end

  assign table_pointer = table_pointer_ff;

  // ------------------------------------------------------------------
  // read data, one cycle after the strobe; zero otherwise
  // ------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_W'(mifd_pkg::REG_CTRL): reg_rdata <= {31'h0, ctrl_en_ff};
        ADDR_W'(mifd_pkg::REG_BANK): reg_rdata <= {28'h0, bank_select_reg_ff};
        ADDR_W'(mifd_pkg::REG_TABLE_PTR): reg_rdata <= {11'h0, table_pointer_ff};
        ADDR_W'(mifd_pkg::REG_STATUS): begin
          reg_rdata <= {6'h0, err_ff, (seq_ff == mifd_pkg::SEQ_SECOND),
                        7'h0, dec_op};
        end
        ADDR_W'(mifd_pkg::REG_WORD): reg_rdata <= {16'h0, last_word_ff};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule
`default_nettype wire

// ---- rtl/mifd_pkg.sv ----
/*
  mifd_pkg: constants, register map, opcode patterns and carrier types
  for the instruction field decoder.
  assumes: included before every rtl file of the decoder; no imports.
*/
package mifd_pkg;

  // ------------------------------------------------------------------
  // instruction cycle timing
  // ------------------------------------------------------------------
  localparam int CYCLE_PERIODS = 4; // oscillator periods per cycle
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;

  // ------------------------------------------------------------------
  // register map (byte offsets on the plain register port)
  // ------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00; // bit0 decode enable
  localparam logic [7:0] REG_BANK = 8'h04; // bank_select_reg
  localparam logic [7:0] REG_TABLE_PTR = 8'h08; // table_pointer
  localparam logic [7:0] REG_STATUS = 8'h0c; // decoder state
  localparam logic [7:0] REG_WORD = 8'h10; // last emitted word
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam int BANK_W = 4;
  localparam int TABLE_PTR_W = 21;
  localparam int STAT_WAIT_BIT = 24;
  localparam int STAT_ERR_BIT = 25;

  // ------------------------------------------------------------------
  // word layout and bank selection
  // ------------------------------------------------------------------
  localparam logic [3:0] NIB_SECOND = 4'hf; // top nibble, second word
  localparam logic [3:0] NIB_CTRL = 4'he; // call/goto nibble
  localparam int DEST_BIT = 9;
  localparam int ACCESS_BIT = 8;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hf;

  // ------------------------------------------------------------------
  // opcode patterns, matched with casez
  // ------------------------------------------------------------------
  localparam logic [15:0] PAT_ADD = 16'b0010_01??_????_????;
  localparam logic [15:0] PAT_ADDC = 16'b0010_00??_????_????;
  localparam logic [15:0] PAT_DECSZ = 16'b0010_11??_????_????;
  localparam logic [15:0] PAT_DECSNZ = 16'b0100_11??_????_????;
  localparam logic [15:0] PAT_AND = 16'b0001_01??_????_????;
  localparam logic [15:0] PAT_COMP = 16'b0001_11??_????_????;
  localparam logic [15:0] PAT_CLR = 16'b0110_101?_????_????;
  localparam logic [15:0] PAT_CPEQ = 16'b0110_001?_????_????;
  localparam logic [15:0] PAT_CPGT = 16'b0110_010?_????_????;
  localparam logic [15:0] PAT_CPLT = 16'b0110_000?_????_????;
  localparam logic [15:0] PAT_FILE_MOVE = 16'b1100_????_????_????;
  localparam logic [15:0] PAT_GOTO = 16'b1110_1111_????_????;
  localparam logic [15:0] PAT_CALL = 16'b1110_110?_????_????;
  localparam logic [15:0] PAT_RET = 16'b0000_0000_0001_00??;
  localparam logic [15:0] PAT_REL_BRANCH = 16'b1101_0???_????_????;
  localparam logic [15:0] PAT_LIT = 16'b0000_1???_????_????;
  localparam logic [15:0] PAT_SECOND = 16'b1111_????_????_????;

  // ------------------------------------------------------------------
  // status flag masks, order {c, dc, z, ov, n}
  // ------------------------------------------------------------------
  localparam logic [4:0] FLG_ARITH = 5'h1f;
  localparam logic [4:0] FLG_ZN = 5'h05;
  localparam logic [4:0] FLG_Z = 5'h04;
  localparam logic [4:0] FLG_NONE = 5'h00;

  // ------------------------------------------------------------------
  // carrier types
  // ------------------------------------------------------------------
  typedef enum logic [16:0] {
    OP_NOP = 17'h00001, OP_ADD = 17'h00002, OP_ADDC = 17'h00004,
    OP_AND = 17'h00008, OP_COMP = 17'h00010, OP_CLR = 17'h00020,
    OP_CPEQ = 17'h00040, OP_CPGT = 17'h00080, OP_CPLT = 17'h00100,
    OP_DECSZ = 17'h00200, OP_DECSNZ = 17'h00400, OP_FILE_MOVE = 17'h00800,
    OP_GOTO = 17'h01000, OP_CALL = 17'h02000, OP_RET = 17'h04000,
    OP_REL_BRANCH = 17'h08000, OP_OTHER = 17'h10000
  } mifd_op_t;

  typedef enum logic [1:0] {
    SEQ_FIRST = 2'b01, // expecting an opening word
    SEQ_SECOND = 2'b10 // expecting the 1111 second word
  } mifd_seq_t;

  typedef struct packed {
    logic [7:0] file_addr; // byte/bit file address
    logic dest_file; // d bit
    logic bank_sel; // a bit
    logic [2:0] bit_pos; // bit number
    logic [7:0] literal; // low byte immediate
    logic [10:0] branch_off; // relative offset
    logic fast; // s bit
  } mifd_fields_t;

endpackage

// ---- rtl/mifd_field_split.sv ----
/*
  mifd_field_split: pulls the operand fields out of one 16-bit word.
  assumes: purely combinational; the caller picks which word to split.
*/
`timescale 1ns/1ps
`default_nettype none
module mifd_field_split (
  // word in
  input wire logic [15:0] word,
  // fields out
  output mifd_pkg::mifd_fields_t fields
);
  // ------------------------------------------------------------------
  // field extraction
  // ------------------------------------------------------------------
  assign fields.file_addr = word[7:0];
  assign fields.dest_file = word[mifd_pkg::DEST_BIT];
  assign fields.bank_sel = word[mifd_pkg::ACCESS_BIT];
  assign fields.bit_pos = word[11:9];
  assign fields.literal = word[7:0];
  assign fields.branch_off = word[10:0];
  // call keeps s next to its opcode, returns keep it in bit 0
  assign fields.fast = (word[15:12] == mifd_pkg::NIB_CTRL) ?
                       word[8] : word[0];
endmodule
`default_nettype wire

// ---- rtl/mifd_phase_gen.sv ----
/*
  mifd_phase_gen: counts oscillator periods inside one instruction cycle.
  assumes: clk is the oscillator; sys_rst asynchronous, active high.
*/
`timescale 1ns/1ps
`default_nettype none
module mifd_phase_gen #(
  parameter int PERIODS = mifd_pkg::CYCLE_PERIODS
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // phase marks
  output logic cyc_first,
  output logic cyc_last
);
  localparam int CW = $clog2(PERIODS);

  // refuse cycles the counter cannot express
  if (PERIODS < 2) begin : g_chk
    $error("PERIODS must be at least 2");
  end

  logic [CW-1:0] phase_ff; // period index in the cycle

  // ------------------------------------------------------------------
  // period counter, wraps every instruction cycle
  // ------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_ff <= '0;
    end else if (phase_ff == CW'(PERIODS - 1)) begin
      phase_ff <= '0;
    end else begin
      phase_ff <= phase_ff + CW'(1);
    end
  end

  assign cyc_first = (phase_ff == '0);
  assign cyc_last = (phase_ff == CW'(PERIODS - 1));
endmodule
`default_nettype wire

// ---- verification/mifd_decoder_sva.sv ----
/* checker: decode output relations of mifd_decoder
   assumes: bound to every mifd_decoder, one clock, default cycle length */
`timescale 1ns/1ps
`default_nettype none
module mifd_decoder_sva (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // watched outputs
  input wire logic fetch_req,
  input wire logic dec_valid,
  input wire mifd_pkg::mifd_op_t dec_op,
  input wire mifd_pkg::mifd_fields_t dec_fields,
  input wire logic [11:0] dec_file_addr,
  input wire logic dec_result_to_file,
  input wire logic [4:0] dec_flag_mask,
  input wire logic dec_skip_cond,
  input wire logic shadow_save,
  input wire logic shadow_restore
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // three idle clocks, then the next fetch
  sequence s_gap;
    (!fetch_req) [*3] ##1 fetch_req;
  endsequence
  a_fetch_cadence: assert property (fetch_req |=> s_gap)
    else $error("fetch cadence broken");
  a_decode_rate: assert property (dec_valid |=> (!dec_valid) [*3])
    else $error("decode faster than one cycle");
  a_restore_mode: assert property (dec_valid && dec_op == mifd_pkg::OP_RET |->
    shadow_restore == dec_fields.fast) else $error("restore mode wrong");
  a_save_call: assert property (shadow_save |-> dec_valid && dec_op == mifd_pkg::OP_CALL)
    else $error("save outside call");
  a_arith_flags: assert property (dec_valid && dec_op inside {mifd_pkg::OP_ADD,
    mifd_pkg::OP_ADDC} |-> dec_flag_mask == 5'h1f) else $error("add flags wrong");
  a_skip_flags: assert property (dec_valid && dec_skip_cond |-> dec_flag_mask == 5'h00)
    else $error("skip op touches flags");
  a_dest_select: assert property (dec_valid && dec_skip_cond && dec_op != mifd_pkg::OP_CPEQ
    && !dec_op[7] && !dec_op[8] |-> dec_result_to_file == dec_fields.dest_file)
    else $error("destination wrong");
  a_access_bank: assert property (dec_valid && dec_skip_cond && !dec_fields.bank_sel |->
    dec_file_addr[11:8] == (dec_fields.file_addr[7] ? 4'hf : 4'h0)) else $error("bank wrong");
endmodule
bind mifd_decoder mifd_decoder_sva sva (.*);
`default_nettype wire

// ---- verification/mifd_prog_mem.sv ----
/* program memory model: one word for each fetch request
   assumes: the bench loads prog and n before fetches reach them */
`timescale 1ns/1ps
`default_nettype none
module mifd_prog_mem (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // fetch side
  input wire logic fetch_req,
  output logic [15:0] instr_word,
  output logic instr_valid
);
  logic [15:0] prog [256]; // program words
  int n = 0; // words loaded
  int ptr; // next word
  // answer the cycle after a request; an idle bus inverts its word every clock
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ptr <= 0;
      instr_valid <= 1'b0;
      instr_word <= 16'h0000;
    end else if (fetch_req && ptr < n) begin
      instr_word <= prog[ptr];
      instr_valid <= 1'b1;
      ptr <= ptr + 1;
    end else begin
      instr_valid <= 1'b0;
      instr_word <= ~instr_word;
    end
  end
endmodule
`default_nettype wire

// ---- verification/test_mcu_instruction_field_decoder.sv ----
/* testbench: random opcode stream through the decoder, fields checked
   assumes: mifd_prog_mem beside mifd_decoder, checker bound */
`timescale 1ns/1ps
`default_nettype none
module test_mcu_instruction_field_decoder;
  logic clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, fetch_req, instr_valid, dec_valid;
  logic [7:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata;
  logic [15:0] instr_word, w, wq[$];
  logic [11:0] vq[$]; // destination or high target bits of second words
  logic [11:0] dec_file_addr, dec_src_addr, dec_dst_addr;
  logic [19:0] dec_target;
  logic [20:0] table_pointer;
  logic [4:0] dec_flag_mask;
  logic [3:0] bank;
  logic [1:0] dec_cycles;
  logic dec_result_to_file, dec_skip_cond, shadow_save, shadow_restore;
  mifd_pkg::mifd_op_t dec_op;
  mifd_pkg::mifd_fields_t dec_fields;
  int errors = 0, compares = 0, r, k, kq[$];
  // opcode base and free bits, indexed by the one-hot position of the op
  localparam logic [15:0] BASE [17] = '{16'hf000, 16'h2400, 16'h2000, 16'h1400, 16'h1c00,
    16'h6a00, 16'h6200, 16'h6400, 16'h6000, 16'h2c00, 16'h4c00, 16'hc000, 16'hef00,
    16'hec00, 16'h0010, 16'hd000, 16'h0800};
  localparam logic [15:0] MSK [17] = '{16'h0fff, 16'h03ff, 16'h03ff, 16'h03ff, 16'h03ff,
    16'h01ff, 16'h01ff, 16'h01ff, 16'h01ff, 16'h03ff, 16'h03ff, 16'h0fff, 16'h00ff,
    16'h01ff, 16'h0003, 16'h07ff, 16'h07ff};
  mifd_decoder uut (.*);
  mifd_prog_mem mem (.*);
  always #10 clk = ~clk;
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // register port: one strobe cycle; read data in the following cycle
  task automatic rw(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= wr;
    reg_rd <= !wr;
    @(posedge clk);
    reg_wr <= 0;
    reg_rd <= 0;
    @(negedge clk);
    if (!wr) chk(reg_rdata, d);
  endtask
  // each decode result against the word that produced it
  always @(negedge clk) if (dec_valid === 1'b1) begin
    k = kq.pop_front();
    w = wq.pop_front();
    chk(dec_op, 32'h1 << k);
    chk(dec_flag_mask, (k == 1 || k == 2) ? 5'h1f : (k == 3 || k == 4) ? 5'h05 :
      (k == 5) ? 5'h04 : 5'h00);
    chk({dec_skip_cond, dec_cycles}, {k > 5 && k < 11, (k > 10 && k < 16) ? 2'h2 : 2'h1});
    chk(dec_result_to_file, k == 5 || ((k < 5 || k == 9 || k == 10) && k > 0 && w[9]));
    chk({shadow_save, shadow_restore}, {k == 13 && w[8], k == 14 && w[0]});
    if (k < 11 || k > 13) chk(dec_fields, {w[7:0], w[9], w[8], w[11:9], w[7:0], w[10:0], w[0]});
    if (k > 0 && k < 11) chk(dec_file_addr, {w[8] ? bank : {4{w[7]}}, w[7:0]});
    if (k == 11) chk({dec_src_addr, dec_dst_addr}, {w[11:0], vq.pop_front()});
    if (k == 12 || k == 13) chk(dec_target, {vq.pop_front(), w[7:0]});
  end
  initial begin
    void'($urandom(32'hed8f5a83));
    repeat (5) @(posedge clk);
    sys_rst <= 0;
    bank = 4'($urandom);
    rw(1, 8'h04, {28'h0, bank});
    rw(1, 8'h08, 32'hffffffff);
    rw(0, 8'h08, 32'h001fffff);
    chk(table_pointer, 21'h1fffff);
    rw(0, 8'h24, 32'h0);
    rw(0, 8'h00, 32'h1);
    // all free bits set, then all clear then random
    for (r = 0; r < 119; r++) begin
      k = r % 17;
      w = BASE[k] | (r < 17 ? MSK[k] : r < 34 ? 16'h0 : 16'($urandom) & MSK[k]);
      kq.push_back(k);
      wq.push_back(w);
      mem.prog[mem.n] = w;
      mem.n++;
      if (k > 10 && k < 14) begin
        vq.push_back(12'($urandom));
        mem.prog[mem.n] = {4'hf, vq[$]};
        mem.n++;
      end
    end
    repeat (3000) if (kq.size() > 0) @(posedge clk);
    chk(kq.size(), 0);
    // opening move word, then a word lacking 1111: pair dropped as no-op
    mem.prog[mem.n] = 16'hc123;
    mem.prog[mem.n + 1] = 16'h2abc;
    kq.push_back(0);
    wq.push_back(16'h2abc);
    mem.n += 2;
    repeat (100) if (kq.size() > 0) @(posedge clk);
    chk(kq.size(), 0);
    rw(0, 8'h0c, 32'h0200_0001);
    rw(0, 8'h10, 32'h0000_2abc);
    rw(1, 8'h0c, 32'h0200_0000);
    rw(0, 8'h0c, 32'h0000_0001);
    close_out();
  end
  initial begin
    #100us;
    errors++;
    close_out();
  end
endmodule
`default_nettype wire
